// >>> rtl/owd_decoder.v
/*
  option word decoder: holds the programmed option words, loads them
  once after reset and drives the decoded chip settings.
  assumes a programmer on the plain register port and dependent logic
  that waits for cfg_valid_q before using any setting.
*/
// Summary of operation
// RULE1: protect bit low enables code protection
// RULE2: mode bit low disables usb controller
// RULE3: pull-up bit low connects D+ resistor; code connects it only while the usb mode bit is high
// RULE4: start field sets oscillator start, watchdog
// RULE5: clock field selects crystal times 2/4/6
// RULE6: package field selects 20/24/40/44 pins
// RULE7: hold bit low halts cpu during conversion
// RULE8: programmer writes zero into bit nine
// RULE9: programmer writes zero into bits 11, 12
// RULE10: layouts 000-100 set endpoints and fifo sizes
// RULE11: layouts 101-111 set endpoints; rest disabled
// RULE12: endpoint type and direction fields decoded
// RULE13: packet size clipped to fifo size
// RULE14: version bit zero selects spi variant
// RULE15: owner tag stored, no behavioural effect
// RULE16: words loaded once after reset, then held
`timescale 1ns/1ns
`default_nettype none
`include "owd_consts.vh"

module owd_decoder
#(
  parameter [`OWD_CYC_W-1:0] START_CYC0 = `OWD_START_CYC0,
  parameter [`OWD_CYC_W-1:0] START_CYC1 = `OWD_START_CYC1,
  parameter [`OWD_CYC_W-1:0] START_CYC2 = `OWD_START_CYC2,
  parameter [`OWD_CYC_W-1:0] START_CYC3 = `OWD_START_CYC3
)
(
  input wire ref_clk,
  input wire rst_b,
  input wire [`OWD_REG_ADDR_W-1:0] reg_addr,
  input wire [`OWD_WORD_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`OWD_WORD_W-1:0] reg_rdata_q,
  output reg cfg_valid_q,
  output reg protect_en_q,
  output reg usb_mode_q,
  output reg dp_pullup_en_q,
  output reg [1:0] start_time_sel_q,
  output reg [`OWD_CYC_W-1:0] start_cycles_q,
  output reg [2:0] clk_mult_q,
  output reg clk_sel_bad_q,
  output reg [5:0] pin_count_q,
  output reg adc_hold_en_q,
  output reg [4:0] ep_enable_q,
  output reg [9:0] ep_xfer_kind_q,
  output reg [4:0] ep_dir_q,
  output reg [34:0] ep_fifo_bytes_q,
  output reg [34:0] ep_pkt_bytes_q,
  output reg spi_variant_q,
  output reg [`OWD_OWNER_W-1:0] owner_tag_q
);

  localparam [1:0] ST_LOAD = 2'h0;
  localparam [1:0] ST_DEC = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`OWD_ADDR_W-1:0] cnt_q;
  reg cap_vld_q;
  reg [`OWD_ADDR_W-1:0] cap_idx_q;
  reg [`OWD_OPT_W-1:0] opt_q;
  reg fixed_bad_q;
  reg kind_bad_q;
  wire [`OWD_WORD_W-1:0] mem_rdata;
  wire load_rd;
  wire prog_wr;

  // ************************************************************
  // option word storage
  // ************************************************************
  assign prog_wr = reg_wr &&
    (reg_addr[`OWD_REG_ADDR_W-1:`OWD_ADDR_W] == 1'h0) &&
    (reg_addr[`OWD_ADDR_W-1:0] <= `OWD_LAST_ADDR);
  assign load_rd = (state_q == ST_LOAD) && (cnt_q <= `OWD_LAST_ADDR);

  owd_opt_store i_owd_opt_store
  (
    .ref_clk(ref_clk),
    .wr_en(prog_wr),
    .wr_addr(reg_addr[`OWD_ADDR_W-1:0]),
    .wr_data(reg_wdata),
    .rd_en(load_rd),
    .rd_addr(cnt_q),
    .rd_data_q(mem_rdata)
  );

  // ************************************************************
  // loader: one pass over the words after reset, then idle
  // ************************************************************
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_LOAD:
        if (cap_vld_q && (cap_idx_q == `OWD_LAST_ADDR))
          state_d = ST_DEC;
      ST_DEC:
        state_d = ST_DONE;
      ST_DONE:
        state_d = ST_DONE; // RULE16
      default:
        state_d = ST_LOAD;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_q <= ST_LOAD;
      cnt_q <= 3'h0;
      cap_vld_q <= 1'b0;
      cap_idx_q <= 3'h0;
      opt_q <= {`OWD_OPT_W{1'b1}};
    end
    else
    begin
      state_q <= state_d;
      cap_vld_q <= load_rd;
      cap_idx_q <= cnt_q;
      if (load_rd)
        cnt_q <= cnt_q + 3'h1;
      if (cap_vld_q)
        opt_q[cap_idx_q*`OWD_WORD_W +: `OWD_WORD_W] <= mem_rdata; // RULE16
    end
  end

  // ************************************************************
  // endpoint decode
  // ************************************************************
  function [2:0] ep_map;
    input [2:0] sel;
    input integer idx;
    reg [14:0] row;
    begin
      case (sel)
        3'h0: row = `OWD_EPMAP_000; // RULE10
        3'h1: row = `OWD_EPMAP_001; // RULE10
        3'h2: row = `OWD_EPMAP_010; // RULE10
        3'h3: row = `OWD_EPMAP_011; // RULE10
        3'h4: row = `OWD_EPMAP_100; // RULE10
        3'h5: row = `OWD_EPMAP_101; // RULE11
        3'h6: row = `OWD_EPMAP_110; // RULE11
        default: row = `OWD_EPMAP_111; // RULE11
      endcase
      ep_map = row[idx*3 +: 3];
    end
  endfunction

  function [6:0] bytes_of;
    input [1:0] code;
    begin
      case (code)
        2'h0: bytes_of = `OWD_BYTES_8;
        2'h1: bytes_of = `OWD_BYTES_16;
        2'h2: bytes_of = `OWD_BYTES_32;
        default: bytes_of = `OWD_BYTES_64;
      endcase
    end
  endfunction

  wire [2:0] layout_sel;
  wire [4:0] ep_en_d;
  wire [9:0] ep_kind_d;
  wire [4:0] ep_dir_d;
  wire [34:0] ep_fifo_d;
  wire [34:0] ep_pkt_d;
  wire [4:0] ep_kind_bad;

  assign layout_sel = opt_q[`OWD_B_EP_LAYOUT_LO +: 3];

  genvar g;
  generate
    for (g = 0; g < `OWD_NUM_EP; g = g + 1)
    begin : g_ep
      localparam integer BASE = `OWD_B_EP_BASE + g * `OWD_EP_STRIDE;
      wire [2:0] map = ep_map(layout_sel, g);
      wire [1:0] size_code = opt_q[BASE+3 +: 2];
      // a disabled endpoint reports no fifo and no packet size
      wire [1:0] eff_code = (size_code > map[1:0]) ? map[1:0] :
        size_code; // RULE13
      assign ep_en_d[g] = map[2] & opt_q[`OWD_B_USB_MODE]; // RULE2
      assign ep_kind_d[2*g +: 2] = opt_q[BASE +: 2]; // RULE12
      assign ep_dir_d[g] = opt_q[BASE+2]; // RULE12
      assign ep_fifo_d[7*g +: 7] = ep_en_d[g] ? bytes_of(map[1:0]) :
        7'h00;
      assign ep_pkt_d[7*g +: 7] = ep_en_d[g] ? bytes_of(eff_code) :
        7'h00; // RULE13
      // type code 00 is undefined; only flagged on live endpoints
      assign ep_kind_bad[g] = ep_en_d[g] &&
        (opt_q[BASE +: 2] == 2'h0); // RULE12
    end
  endgenerate

  // ************************************************************
  // chip level decode
  // ************************************************************
  reg [`OWD_CYC_W-1:0] start_cyc_d;
  reg [2:0] mult_d;
  reg [5:0] pins_d;

  always @*
  begin
    case (opt_q[`OWD_B_START_LO +: 2])
      2'h0: start_cyc_d = START_CYC0; // RULE4
      2'h1: start_cyc_d = START_CYC1; // RULE4
      2'h2: start_cyc_d = START_CYC2; // RULE4
      default: start_cyc_d = START_CYC3; // RULE4
    endcase
    case (opt_q[`OWD_B_CLK_LO +: 2])
      2'h0: mult_d = `OWD_MULT_X2; // RULE5
      2'h1: mult_d = `OWD_MULT_X4; // RULE5
      2'h2: mult_d = `OWD_MULT_X6; // RULE5
      default: mult_d = `OWD_MULT_NONE; // RULE5
    endcase
    case (opt_q[`OWD_B_PIN_LO +: 2])
      2'h0: pins_d = `OWD_PINS_20; // RULE6
      2'h1: pins_d = `OWD_PINS_24; // RULE6
      2'h2: pins_d = `OWD_PINS_40; // RULE6
      default: pins_d = `OWD_PINS_44; // RULE6
    endcase
  end

  // ************************************************************
  // settings: safe values until the load ends, then frozen
  // ************************************************************
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      cfg_valid_q <= 1'b0;
      protect_en_q <= 1'b1;
      usb_mode_q <= 1'b0;
      dp_pullup_en_q <= 1'b0;
      start_time_sel_q <= 2'h3;
      start_cycles_q <= START_CYC3;
      clk_mult_q <= `OWD_MULT_NONE;
      clk_sel_bad_q <= 1'b0;
      pin_count_q <= 6'h00;
      adc_hold_en_q <= 1'b0;
      ep_enable_q <= 5'h00;
      ep_xfer_kind_q <= 10'h000;
      ep_dir_q <= 5'h00;
      ep_fifo_bytes_q <= 35'h0_0000_0000;
      ep_pkt_bytes_q <= 35'h0_0000_0000;
      spi_variant_q <= 1'b0;
      owner_tag_q <= 17'h0_0000;
      fixed_bad_q <= 1'b0;
      kind_bad_q <= 1'b0;
    end
    else if (state_q == ST_DEC)
    begin
      cfg_valid_q <= 1'b1; // RULE16
      protect_en_q <= ~opt_q[`OWD_B_PROTECT_N]; // RULE1
      usb_mode_q <= opt_q[`OWD_B_USB_MODE]; // RULE2
      // the pull-up means nothing with the transceiver closed
      dp_pullup_en_q <= ~opt_q[`OWD_B_PULLUP_N] &
        opt_q[`OWD_B_USB_MODE]; // RULE3
      start_time_sel_q <= opt_q[`OWD_B_START_LO +: 2]; // RULE4
      start_cycles_q <= start_cyc_d; // RULE4
      clk_mult_q <= mult_d; // RULE5
      clk_sel_bad_q <= (opt_q[`OWD_B_CLK_LO +: 2] == 2'h3); // RULE5
      pin_count_q <= pins_d; // RULE6
      adc_hold_en_q <= ~opt_q[`OWD_B_ADC_RUN]; // RULE7
      ep_enable_q <= ep_en_d; // RULE10
      ep_xfer_kind_q <= ep_kind_d; // RULE12
      ep_dir_q <= ep_dir_d; // RULE12
      ep_fifo_bytes_q <= ep_fifo_d; // RULE11
      ep_pkt_bytes_q <= ep_pkt_d; // RULE13
      spi_variant_q <= ~opt_q[`OWD_B_VER_SEL]; // RULE14
      owner_tag_q <= opt_q[`OWD_B_OWNER_LO +: `OWD_OWNER_W]; // RULE15
      // fixed bits are only reported; decode goes ahead regardless
      fixed_bad_q <= opt_q[`OWD_B_FIXED_ZERO] | // RULE8
        opt_q[`OWD_B_FIXED_ZERO_A] | opt_q[`OWD_B_FIXED_ZERO_B]; // RULE9
      kind_bad_q <= |ep_kind_bad;
    end
  end

  // ************************************************************
  // register read port
  // ************************************************************
  always @(posedge ref_clk)
  begin
    if (!rst_b)
      reg_rdata_q <= 13'h0000;
    else if (reg_rd)
    begin
      if (reg_addr == `OWD_STATUS_ADDR)
        reg_rdata_q <= {8'h00, kind_bad_q, fixed_bad_q, clk_sel_bad_q,
          (state_q != ST_DONE), cfg_valid_q};
      else if ((reg_addr[`OWD_REG_ADDR_W-1:`OWD_ADDR_W] == 1'h0) &&
        (reg_addr[`OWD_ADDR_W-1:0] <= `OWD_LAST_ADDR))
        // loaded copy, not the store: shows what the chip runs with
        reg_rdata_q <= opt_q[reg_addr[`OWD_ADDR_W-1:0]*`OWD_WORD_W +:
          `OWD_WORD_W];
      else
        reg_rdata_q <= 13'h0000;
    end
    else
      reg_rdata_q <= 13'h0000;
  end

endmodule // owd_decoder

`default_nettype wire

// >>> pkg/owd_consts.vh
/*
  option word decoder constants: word layout, field positions, reset
  values and start-time figures.
  assumes a 125 MHz ref_clk and six 13-bit option words.
*/
`ifndef OWD_CONSTS_VH
`define OWD_CONSTS_VH

// ************************************************************
// storage geometry
// ************************************************************
`define OWD_WORD_W 13
`define OWD_NUM_WORDS 6
`define OWD_OPT_W 78
`define OWD_ADDR_W 3
`define OWD_REG_ADDR_W 4
`define OWD_LAST_ADDR 3'h5
`define OWD_STATUS_ADDR 4'h6
`define OWD_ERASED_WORD 13'h1fff

// ************************************************************
// bit positions in the flat option vector
// ************************************************************
`define OWD_B_PROTECT_N 0
`define OWD_B_USB_MODE 1
`define OWD_B_PULLUP_N 2
`define OWD_B_START_LO 3
`define OWD_B_CLK_LO 5
`define OWD_B_PIN_LO 7
`define OWD_B_FIXED_ZERO 9
`define OWD_B_ADC_RUN 10
`define OWD_B_FIXED_ZERO_A 11
`define OWD_B_FIXED_ZERO_B 12
`define OWD_B_EP_LAYOUT_LO 13
`define OWD_B_EP_BASE 16
`define OWD_EP_STRIDE 5
`define OWD_NUM_EP 5
`define OWD_B_OWNER_LO 43
`define OWD_OWNER_W 17
`define OWD_B_VER_SEL 65

// ************************************************************
// endpoint layout table: per selection, ep5..ep1 of {enable, size code}
// ************************************************************
`define OWD_EPMAP_000 15'h0007
`define OWD_EPMAP_001 15'h003f
`define OWD_EPMAP_010 15'h01b7
`define OWD_EPMAP_011 15'h0b77
`define OWD_EPMAP_100 15'h4977
`define OWD_EPMAP_101 15'h5b6f
`define OWD_EPMAP_110 15'h0db6
`define OWD_EPMAP_111 15'h5bb6

// ************************************************************
// decoded values
// ************************************************************
`define OWD_MULT_X2 3'h2
`define OWD_MULT_X4 3'h4
`define OWD_MULT_X6 3'h6
`define OWD_MULT_NONE 3'h0
`define OWD_PINS_20 6'h14
`define OWD_PINS_24 6'h18
`define OWD_PINS_40 6'h28
`define OWD_PINS_44 6'h2c
`define OWD_BYTES_8 7'h08
`define OWD_BYTES_16 7'h10
`define OWD_BYTES_32 7'h20
`define OWD_BYTES_64 7'h40

// ************************************************************
// start time / watchdog timeout
// ************************************************************
`define OWD_CLK_MHZ 125
`define OWD_START_T0_US 500
`define OWD_START_T1_MS 2
`define OWD_START_T2_MS 4
`define OWD_START_T3_MS 8
// the four figures above as ref_clk cycles, sized to the counter
`define OWD_START_CYC0 20'h0_f424
`define OWD_START_CYC1 20'h3_d090
`define OWD_START_CYC2 20'h7_a120
`define OWD_START_CYC3 20'hf_4240
`define OWD_CYC_W 20

`endif

// >>> rtl/owd_opt_store.v
/*
  option word store: eight words of 13 bits, one write port, one read
  port whose data come out of a register one cycle after the request.
  assumes the writer never asks for an address above seven.
*/
`timescale 1ns/1ns
`default_nettype none
`include "owd_consts.vh"

module owd_opt_store
(
  input wire ref_clk,
  input wire wr_en,
  input wire [`OWD_ADDR_W-1:0] wr_addr,
  input wire [`OWD_WORD_W-1:0] wr_data,
  input wire rd_en,
  input wire [`OWD_ADDR_W-1:0] rd_addr,
  output reg [`OWD_WORD_W-1:0] rd_data_q
);

  reg [`OWD_WORD_W-1:0] mem [0:7];
  integer i;

  // ************************************************************
  // blank part reads erased (all ones); contents survive reset
  // ************************************************************
  initial
  begin
    for (i = 0; i < 8; i = i + 1)
      mem[i] = `OWD_ERASED_WORD;
  end

  always @(posedge ref_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    if (rd_en)
      rd_data_q <= mem[rd_addr];
  end

endmodule // owd_opt_store

`default_nettype wire

// >>> tb/owd_decoder_monitor.sv
/* checker for the option word decoder settings outputs.
   assumes it is bound onto owd_decoder, one clock, sync reset. */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// settings checker
// ****************************************
module owd_decoder_monitor
#(
  parameter [19:0] START_CYC0 = 20'h0_0001,
  parameter [19:0] START_CYC1 = 20'h0_0001,
  parameter [19:0] START_CYC2 = 20'h0_0001,
  parameter [19:0] START_CYC3 = 20'h0_0001
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [12:0] reg_rdata_q,
  input wire logic cfg_valid_q,
  input wire logic protect_en_q,
  input wire logic usb_mode_q,
  input wire logic dp_pullup_en_q,
  input wire logic [1:0] start_time_sel_q,
  input wire logic [19:0] start_cycles_q,
  input wire logic [2:0] clk_mult_q,
  input wire logic clk_sel_bad_q,
  input wire logic [4:0] ep_enable_q,
  input wire logic [34:0] ep_fifo_bytes_q,
  input wire logic [34:0] ep_pkt_bytes_q
);
  logic [19:0] cyc_exp;
  logic ep_ok;
  assign cyc_exp = start_time_sel_q[1] ?
    (start_time_sel_q[0] ? START_CYC3 : START_CYC2) :
    (start_time_sel_q[0] ? START_CYC1 : START_CYC0);
  // a fifo size shows exactly when the endpoint is on
  always_comb
  begin
    ep_ok = 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      if ((ep_fifo_bytes_q[7*k+:7] != 7'h00) != ep_enable_q[k])
        ep_ok = 1'b0;
      if (ep_pkt_bytes_q[7*k+:7] > ep_fifo_bytes_q[7*k+:7])
        ep_ok = 1'b0;
    end
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  a_load_time:
    assert property ($rose(rst_b) |-> !cfg_valid_q ##[7:9] cfg_valid_q)
    else $error("load did not finish in time");
  a_valid_held:
    assert property (cfg_valid_q |=> cfg_valid_q) else $error("valid lost");
  a_settings_frozen:
    assert property ($past(cfg_valid_q) && cfg_valid_q |-> $stable({
      protect_en_q, usb_mode_q, start_cycles_q, clk_mult_q, ep_pkt_bytes_q}))
    else $error("settings moved while valid");
  a_pullup_usb:
    assert property (dp_pullup_en_q |-> usb_mode_q) else $error("pullup");
  a_usb_off_eps:
    assert property (!usb_mode_q |-> ep_enable_q == 5'h00)
    else $error("endpoint on without usb");
  a_start_cycles:
    assert property (cfg_valid_q |-> start_cycles_q == cyc_exp)
    else $error("start cycles");
  a_clk_bad_flag:
    assert property (cfg_valid_q |-> clk_sel_bad_q == (clk_mult_q == 3'h0))
    else $error("clock flag");
  a_ep_sizes:
    assert property (cfg_valid_q |-> ep_ok) else $error("endpoint sizes");
  a_status_valid:
    assert property (reg_rd && reg_addr == 4'h6 && cfg_valid_q |=>
      reg_rdata_q[0]) else $error("status valid bit");
endmodule // owd_decoder_monitor
bind owd_decoder owd_decoder_monitor #(.START_CYC0(START_CYC0),
  .START_CYC1(START_CYC1), .START_CYC2(START_CYC2),
  .START_CYC3(START_CYC3)) i_owd_decoder_monitor (.*);
`default_nettype wire

// >>> tb/owd_prog_model.sv
/* programmer model: writes option words over the register port.
   assumes callers enter its tasks just after a rising edge. */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// programmer
// ****************************************
module owd_prog_model
(
  input wire logic ref_clk,
  output logic [3:0] reg_addr,
  output logic [12:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [12:0] reg_rdata_q
);
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 13'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // idle bus carries inverted junk so stale values never look valid
  task automatic wr(input logic [3:0] a, input logic [12:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~v;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [12:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    v = reg_rdata_q;
    @(posedge ref_clk);
  endtask
  task automatic load_image(input logic [77:0] img);
    logic [77:0] w;
    w = img;
    w[9] = 1'b0;
    w[12:11] = 2'h0;
    for (int i = 0; i < 6; i++)
      wr(4'(i), w[13*i+:13]);
  endtask
endmodule // owd_prog_model
`default_nettype wire

// >>> tb/owd_decoder_tb_top.sv
/* self-checking bench for the option word decoder.
   assumes the programmer model owns the register port. */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// bench top
// ****************************************
module owd_decoder_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr;
  logic [12:0] reg_wdata, reg_rdata_q, d;
  logic reg_wr, reg_rd, cfg_valid_q, protect_en_q, usb_mode_q;
  logic dp_pullup_en_q, clk_sel_bad_q, adc_hold_en_q, spi_variant_q;
  logic [1:0] start_time_sel_q;
  logic [19:0] start_cycles_q;
  logic [2:0] clk_mult_q;
  logic [5:0] pin_count_q;
  logic [4:0] ep_enable_q, ep_dir_q;
  logic [9:0] ep_xfer_kind_q;
  logic [34:0] ep_fifo_bytes_q, ep_pkt_bytes_q;
  logic [16:0] owner_tag_q;
  logic [77:0] img;
  int err_count = 0;
  int checks = 0;
  int cyc_n = 0;
  int k, e, n, f, p;
  bit usb, en;
  int fifo_t [8][5] = '{'{64, 0, 0, 0, 0}, '{64, 64, 0, 0, 0},
    '{64, 32, 32, 0, 0}, '{64, 32, 16, 16, 0}, '{64, 32, 16, 8, 8},
    '{64, 16, 16, 16, 16}, '{32, 32, 32, 32, 0}, '{32, 32, 32, 16, 16}};
  int cyc_t [4] = '{5, 20, 40, 80};
  int mult_t [4] = '{2, 4, 6, 0};
  int pin_t [4] = '{20, 24, 40, 44};
  always #4 ref_clk = ~ref_clk;
  // short start counts, echoed by cyc_t in the start cycle checks
  owd_decoder #(.START_CYC0(20'h0_0005), .START_CYC1(20'h0_0014),
    .START_CYC2(20'h0_0028), .START_CYC3(20'h0_0050)) i_owd_decoder (.*);
  owd_prog_model i_owd_prog_model (.*);
  task automatic chk(input string nm, input logic [34:0] s, e);
    checks++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("valid in reset", cfg_valid_q, 0);
    @(posedge ref_clk);
    rst_b <= 1'b1;
  endtask
  task automatic wait_valid();
    n = 0;
    while (cfg_valid_q !== 1'b1 && n < 30)
    begin
      @(posedge ref_clk);
      n++;
    end
    #1;
    chk("load done", cfg_valid_q, 1);
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000)
    begin
      err_count++;
      wrap_up();
    end
  end
  initial
  begin
    do_reset();
    // nine images walk every code of every field but the owner tag and the fixed bits, last one non-usb
    for (k = 0; k < 9; k++)
    begin
      img = '0;
      usb = (k < 8);
      img[12:0] = {4'hf, 2'(k + 1), k[2:1], k[1:0], k[1], usb, k[0]};
      img[10] = k[1];
      img[15:13] = k[2:0];
      for (e = 0; e < 5; e++)
        img[16+5*e+:5] = {2'(k + e), k[0] ^ e[0], 2'(k + e + 1)};
      img[59:43] = 17'h1_5a3c ^ 17'(k);
      img[65] = k[2];
      i_owd_prog_model.load_image(img);
      do_reset();
      if (k == 4)
      begin
        // loader still busy at the first edge after release
        i_owd_prog_model.rd(4'h6, d);
        chk("status busy", d, 13'h0002);
      end
      wait_valid();
      chk("protect", protect_en_q, !img[0]);
      chk("usb mode", usb_mode_q, usb);
      chk("pullup", dp_pullup_en_q, !img[2] && usb);
      chk("start sel", start_time_sel_q, img[4:3]);
      chk("start cycles", start_cycles_q, cyc_t[img[4:3]]);
      chk("clk mult", clk_mult_q, mult_t[img[6:5]]);
      chk("clk bad", clk_sel_bad_q, img[6:5] == 2'h3);
      chk("pins", pin_count_q, pin_t[img[8:7]]);
      chk("adc hold", adc_hold_en_q, !img[10]);
      chk("spi", spi_variant_q, !img[65]);
      chk("owner", owner_tag_q, img[59:43]);
      for (e = 0; e < 5; e++)
      begin
        f = fifo_t[k%8][e];
        en = usb && f != 0;
        p = 8 << img[19+5*e+:2];
        if (p > f)
          p = f;
        chk("ep on", ep_enable_q[e], en);
        chk("ep kind", ep_xfer_kind_q[2*e+:2], img[16+5*e+:2]);
        chk("ep dir", ep_dir_q[e], img[18+5*e]);
        chk("ep fifo", ep_fifo_bytes_q[7*e+:7], en ? f : 0);
        chk("ep pkt", ep_pkt_bytes_q[7*e+:7], en ? p : 0);
      end
      if (k == 4)
      begin
        i_owd_prog_model.rd(4'h0, d);
        chk("word0", d, img[12:0] & 13'h05ff);
        i_owd_prog_model.wr(4'h0, {4'h0, ~img[8:0]});
        i_owd_prog_model.rd(4'h0, d);
        chk("word0 held", d, img[12:0] & 13'h05ff);
        chk("protect held", protect_en_q, !img[0]);
        i_owd_prog_model.wr(4'h6, 13'h1fff);
        // valid plus an enabled endpoint of type 00
        i_owd_prog_model.rd(4'h6, d);
        chk("status", d, 13'h0011);
        i_owd_prog_model.rd(4'h9, d);
        chk("unmapped", d, 13'h0000);
      end
      if (k == 6)
      begin
        // undefined clock code and an enabled endpoint of type 00
        i_owd_prog_model.rd(4'h6, d);
        chk("status clk", d, 13'h0015);
      end
    end
    // bit nine set on purpose: decode goes on, the flag shows it
    i_owd_prog_model.wr(4'h0, 13'h0200);
    do_reset();
    wait_valid();
    i_owd_prog_model.rd(4'h6, d);
    chk("status fixed", d, 13'h0009);
    chk("protect on", protect_en_q, 1);
    chk("usb off", usb_mode_q, 0);
    wrap_up();
  end
endmodule // owd_decoder_tb_top
`default_nettype wire
